/* core/sfi_consts.vh */
// constants for the status flag instruction unit
`ifndef SFI_CONSTS_VH
`define SFI_CONSTS_VH
// status register bit positions
`define SFI_BIT_C 3'h0
`define SFI_BIT_Z 3'h1
`define SFI_BIT_N 3'h2
`define SFI_BIT_V 3'h3
`define SFI_BIT_S 3'h4
`define SFI_BIT_H 3'h5
`define SFI_BIT_T 3'h6
`define SFI_BIT_I 3'h7
// reset value of the status register
`define SFI_STATUS_REGISTER_RST 8'h00
// operation codes
`define SFI_OP_NONE 5'h00
`define SFI_OP_BST 5'h01
`define SFI_OP_BLD 5'h02
`define SFI_OP_FSET 5'h03
`define SFI_OP_FCLR 5'h04
// every operation completes in this many cycles
`define SFI_OP_CYCLES 1
`endif

/* core/sfi_flag_cell.v */
// one status flag bit with force-set, force-clear and external load
`timescale 1ns/1ns
module sfi_flag_cell #(
	parameter RST_VAL = 1'b0
) (
	// clock and reset
	input wire i_sys_clk,
	input wire i_reset_n,
	input wire i_ce,
	// controls
	input wire i_set,
	input wire i_clr,
	input wire i_load,
	input wire i_load_val,
	// state
	output reg o_q
);
	// -----------------------------
	// flag storage
	// -----------------------------
	// set wins over clear; load only when neither forced
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_q <= RST_VAL;
		end else if (i_ce) begin
			if (i_set)
				o_q <= 1'b1;
			else if (i_clr)
				o_q <= 1'b0;
			else if (i_load)
				o_q <= i_load_val;
		end
	end
endmodule

/* core/sfi_status_unit.v */
// status flag set/clear and bit transfer execution unit
`timescale 1ns/1ns
`include "sfi_consts.vh"
module sfi_status_unit #(
	parameter DATA_W = 8
) (
	// clock, reset, enable
	input wire i_sys_clk,
	input wire i_reset_n,
	input wire i_ce,
	// operation issue from decode
	input wire i_op_valid,
	input wire [4:0] i_op,
	input wire [2:0] i_flag_sel,
	input wire [2:0] i_bit_sel,
	input wire [DATA_W-1:0] i_reg_data,
	// flag load from the rest of the core
	input wire i_status_register_we,
	input wire [7:0] i_status_register_wdata,
	// results
	output reg [7:0] o_status_register,
	output reg o_reg_we,
	output reg [DATA_W-1:0] o_reg_wdata,
	output reg o_done
);
	// -----------------------------
	// operation qualify
	// -----------------------------
	// an operation is taken on an enabled edge only; with the clock
	// enable low every register below holds, the one-cycle pulses too,
	// so the issuer must keep the enable high across a pulse it counts
	wire go;
	assign go = i_op_valid;

	// -----------------------------
	// operation class decode
	// -----------------------------
	// codes outside the table decode to no class; only the done pulse
	// still answers them, which keeps issue and retire counts in step
	wire is_set;
	wire is_clr;
	wire is_bst;
	wire is_bld;
	assign is_set = go && (i_op == `SFI_OP_FSET);
	assign is_clr = go && (i_op == `SFI_OP_FCLR);
	assign is_bst = go && (i_op == `SFI_OP_BST);
	assign is_bld = go && (i_op == `SFI_OP_BLD);

	// -----------------------------
	// flag select
	// -----------------------------
	// one-hot of the addressed flag, shared by set and clear so the two
	// decodes can never point at different flags
	wire [7:0] flag_hot;
	assign flag_hot = 8'h01 << i_flag_sel;

	// -----------------------------
	// named flag operations
	// -----------------------------
	// each named op touches at most one flag (bit load touches none); the rest keep their value
	// carry
	wire set_carry_op;
	wire clear_carry_op;
	assign set_carry_op = is_set && flag_hot[`SFI_BIT_C];
	assign clear_carry_op = is_clr && flag_hot[`SFI_BIT_C];

	// zero
	wire set_zero_op;
	wire clear_zero_op;
	assign set_zero_op = is_set && flag_hot[`SFI_BIT_Z];
	assign clear_zero_op = is_clr && flag_hot[`SFI_BIT_Z];

	// negative
	wire set_negative_op;
	wire clear_negative_op;
	assign set_negative_op = is_set && flag_hot[`SFI_BIT_N];
	assign clear_negative_op = is_clr && flag_hot[`SFI_BIT_N];

	// two's-complement overflow
	wire set_overflow_op;
	wire clear_overflow_op;
	assign set_overflow_op = is_set && flag_hot[`SFI_BIT_V];
	assign clear_overflow_op = is_clr && flag_hot[`SFI_BIT_V];

	// signed test
	wire set_sign_op;
	wire clear_sign_op;
	assign set_sign_op = is_set && flag_hot[`SFI_BIT_S];
	assign clear_sign_op = is_clr && flag_hot[`SFI_BIT_S];

	// half carry
	wire set_half_carry_op;
	wire clear_half_carry_op;
	assign set_half_carry_op = is_set && flag_hot[`SFI_BIT_H];
	assign clear_half_carry_op = is_clr && flag_hot[`SFI_BIT_H];

	// transfer
	wire set_transfer_bit_op;
	wire clear_transfer_bit_op;
	assign set_transfer_bit_op = is_set && flag_hot[`SFI_BIT_T];
	assign clear_transfer_bit_op = is_clr && flag_hot[`SFI_BIT_T];

	// global interrupt enable
	wire enable_global_irq_op;
	wire disable_global_irq_op;
	assign enable_global_irq_op = is_set && flag_hot[`SFI_BIT_I];
	assign disable_global_irq_op = is_clr && flag_hot[`SFI_BIT_I];

	// bit transfer operations
	wire store_bit_to_transfer_op;
	wire load_bit_from_transfer_op;
	assign store_bit_to_transfer_op = is_bst;
	assign load_bit_from_transfer_op = is_bld;

	// -----------------------------
	// per-flag force vectors
	// -----------------------------
	// packed in status bit order so the cell loop can index them
	wire [7:0] set_v;
	wire [7:0] clr_v;
	assign set_v[`SFI_BIT_C] = set_carry_op;
	assign set_v[`SFI_BIT_Z] = set_zero_op;
	assign set_v[`SFI_BIT_N] = set_negative_op;
	assign set_v[`SFI_BIT_V] = set_overflow_op;
	assign set_v[`SFI_BIT_S] = set_sign_op;
	assign set_v[`SFI_BIT_H] = set_half_carry_op;
	assign set_v[`SFI_BIT_T] = set_transfer_bit_op;
	assign set_v[`SFI_BIT_I] = enable_global_irq_op;
	assign clr_v[`SFI_BIT_C] = clear_carry_op;
	assign clr_v[`SFI_BIT_Z] = clear_zero_op;
	assign clr_v[`SFI_BIT_N] = clear_negative_op;
	assign clr_v[`SFI_BIT_V] = clear_overflow_op;
	assign clr_v[`SFI_BIT_S] = clear_sign_op;
	assign clr_v[`SFI_BIT_H] = clear_half_carry_op;
	assign clr_v[`SFI_BIT_T] = clear_transfer_bit_op;
	assign clr_v[`SFI_BIT_I] = disable_global_irq_op;

	// -----------------------------
	// bit transfer source
	// -----------------------------
	// the store source is taken straight off the register read port;
	// the index is three bits wide, so it cannot leave an 8-bit word
	wire sel_bit;
	assign sel_bit = i_reg_data[i_bit_sel];

	// -----------------------------
	// flag storage
	// -----------------------------
	// a forced set or clear beats a whole-byte load from the core, so a
	// flag op issued beside an arithmetic update still lands
	localparam [7:0] SR_RST = `SFI_STATUS_REGISTER_RST;
	wire [7:0] flags_q;
	wire [7:0] load_v;
	wire [7:0] load_d;
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_flag
			// bit store writes the transfer flag, otherwise the core load
			assign load_v[g] = (store_bit_to_transfer_op && (g == `SFI_BIT_T)) || i_status_register_we;
			assign load_d[g] = (store_bit_to_transfer_op && (g == `SFI_BIT_T)) ?
				sel_bit : i_status_register_wdata[g];
			sfi_flag_cell #(
				.RST_VAL(SR_RST[g])
			) u_cell (
				.i_sys_clk(i_sys_clk),
				.i_reset_n(i_reset_n),
				.i_ce(i_ce),
				.i_set(set_v[g]),
				.i_clr(clr_v[g]),
				.i_load(load_v[g]),
				.i_load_val(load_d[g]),
				.o_q(flags_q[g])
			);
		end
	endgenerate

	// -----------------------------
	// next outputs
	// -----------------------------
	// next status follows the cell priority so the port equals the cells
	// after every edge; bit load leaves every flag alone
	// the bit load reads the transfer flag as it stood before this edge,
	// so a store and a load issued back to back see the stored bit
	reg [7:0] status_d;
	reg [DATA_W-1:0] wdata_d;
	always @* begin
		status_d = set_v | (flags_q & ~clr_v & ~load_v) | (load_v & load_d & ~clr_v);
		wdata_d = i_reg_data;
		if (load_bit_from_transfer_op) begin
			wdata_d[i_bit_sel] = flags_q[`SFI_BIT_T];
		end
	end

	// -----------------------------
	// output registers
	// -----------------------------
	// every port is a flop; done answers any valid code, known or not
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_status_register <= `SFI_STATUS_REGISTER_RST;
			o_reg_we <= 1'b0;
			o_reg_wdata <= {DATA_W{1'b0}};
			o_done <= 1'b0;
		end else if (i_ce) begin
			o_status_register <= status_d;
			o_reg_we <= load_bit_from_transfer_op;
			o_reg_wdata <= wdata_d;
			o_done <= go;
		end
	end
endmodule

/* dv/sfi_status_unit_monitor.sv */
// checker for the status flag unit
`timescale 1ns/1ns
module sfi_status_unit_mon(input wire i_sys_clk, input wire i_reset_n, input wire i_ce,
	input wire i_op_valid, input wire [4:0] i_op, input wire [2:0] i_flag_sel,
	input wire [2:0] i_bit_sel, input wire [7:0] i_reg_data, input wire i_status_register_we,
	input wire [7:0] o_status_register, input wire o_reg_we, input wire o_done);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	// an op is taken only on an enabled edge
	wire go = i_ce & i_op_valid;
	wire [7:0] sr = o_status_register;
	a_flag_set: assert property (go && i_op == 5'h03 && !i_status_register_we |=>
		sr == ($past(sr) | 8'h01 << $past(i_flag_sel))) else $error("flag set");
	a_flag_clr: assert property (go && i_op == 5'h04 && !i_status_register_we |=>
		sr == ($past(sr) & ~(8'h01 << $past(i_flag_sel)))) else $error("flag clear");
	a_store_t: assert property (go && i_op == 5'h01 && !i_status_register_we |=>
		sr[6] == $past(i_reg_data[i_bit_sel])) else $error("bit store");
	a_load_we: assert property (go && i_op == 5'h02 |=> o_reg_we) else $error("bit load");
	a_load_keep: assert property (go && i_op == 5'h02 && !i_status_register_we |=>
		$stable(sr)) else $error("load touched flags");
	a_done_pulse: assert property (go |=> o_done) else $error("no done");
	a_idle_quiet: assert property (i_ce && !i_op_valid |=> !o_done && !o_reg_we) else $error("spurious");
	a_ce_freeze: assert property (!i_ce |=> $stable(sr)) else $error("frozen flags moved");
	cover property (go && i_op == 5'h03);
	cover property (go && i_op == 5'h02);
	cover property (!i_ce);
endmodule
bind sfi_status_unit sfi_status_unit_mon mon(.*);

/* dv/sfi_dec_model.sv */
// decode-side model: issues one packed operation word per cycle
`timescale 1ns/1ns
module sfi_dec_model(input wire i_sys_clk, input wire [31:0] i_word, output reg [31:0] o_issue);
	initial o_issue = 32'h0;
	// launch on the falling edge so the unit samples a settled word
	always @(negedge i_sys_clk) o_issue <= i_word;
endmodule

/* dv/testbench.sv */
// self-checking bench for the status flag unit
`timescale 1ns/1ns
module testbench;
	reg clk = 0, rst_n = 0;
	reg [31:0] w = 0;
	reg [7:0] sr = 0, e, ew = 0, er = 0;
	integer bad_count = 0, comparisons = 0, n;
	wire [31:0] q;
	wire [7:0] st, rd;
	wire we, dn;
	always #10 clk = ~clk;
	sfi_dec_model dec(.i_sys_clk(clk), .i_word(w), .o_issue(q));
	sfi_status_unit uut(.i_sys_clk(clk), .i_reset_n(rst_n), .i_ce(q[0]), .i_op_valid(q[1]),
		.i_op({2'h0, q[4:2]}), .i_flag_sel(q[7:5]), .i_bit_sel(q[10:8]), .i_reg_data(q[18:11]),
		.i_status_register_we(q[19] & q[20]), .i_status_register_wdata(q[28:21]), .o_status_register(st),
		.o_reg_we(we), .o_reg_wdata(rd), .o_done(dn));
	// next flags: ce low freezes, forced ops win over the core load
	function [7:0] nx(input [31:0] x, input [7:0] s);
		begin
			nx = (x[0] & x[19] & x[20]) ? x[28:21] : s;
			if (x[0] & x[1]) case (x[4:2])
				3'h1: nx[6] = x[11 + x[10:8]];
				3'h3: nx[x[7:5]] = 1'b1;
				3'h4: nx[x[7:5]] = 1'b0;
			endcase
		end
	endfunction
	task ck(input [7:0] a, input [7:0] b);
		begin
			comparisons = comparisons + 1;
			if (a !== b) begin
				bad_count = bad_count + 1;
				$display("Error %0t: output mismatch", $time);
			end
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d errors %0d", comparisons, bad_count);
			if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
			else $display("== FAILED ==");
			$finish;
		end
	endtask
	// first 16 words sweep set then clear of every flag, then random words
	initial begin
		n = $urandom(53463);
		repeat (5) @(posedge clk);
		@(negedge clk) rst_n = 1;
		for (n = 0; n < 600; n = n + 1) begin
			@(negedge clk);
			e = nx(q, sr);
			ck(st, e);
			// pulses and write data hold while the enable is low
			if (q[0]) begin
				ew = {6'h0, q[1] & (q[4:2] == 3'h2), q[1]};
				er = q[18:11];
				if (q[1] & (q[4:2] == 3'h2)) er[q[10:8]] = sr[6];
			end
			ck({6'h0, we, dn}, ew);
			ck(rd, er);
			sr = e;
			w <= (n < 16) ? (32'h3 | (n[3] ? 32'h10 : 32'hC) | (n[2:0] << 5)) : $urandom;
		end
		wrap_up;
	end
endmodule
